// ===== hdl/todc_tick_div.sv
// one-second tick divider
`timescale 1ns/1ps
`default_nettype none
module todc_tick_div #(
  parameter int unsigned CYCLES = todc_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic restart,
  // tick
  output logic tick
);
  initial
  begin
    if (CYCLES < 2)
      $error("tick divider needs at least two cycles");
  end

  logic [31:0] cnt;
  logic [31:0] next_cnt;
  localparam logic [31:0] LAST = 32'(CYCLES - 1);

  always_comb
  begin
    if (restart || cnt == LAST)
      next_cnt = 32'h0000_0000;
    else
      next_cnt = cnt + 32'h0000_0001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt <= 32'h0000_0000;
    else
      cnt <= next_cnt;
  end

  assign tick = (cnt == LAST) && !restart;
endmodule // todc_tick_div
`default_nettype wire

// ===== hdl/todc_top.sv
// time-of-day clock with zone offset, APB slave
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module todc_top #(
  parameter int unsigned TICK_CYCLES = todc_pkg::TICK_CYCLES,
  parameter int unsigned DAY_W = 16,
  parameter bit PRECISION_RTC = 1'b0
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // network time server reply
  input wire logic srv_valid,
  input wire logic [31:0] srv_value,
  // non-volatile settings store
  output logic nv_save_req,
  output logic [4:0] nv_save_data,
  input wire logic nv_load_valid,
  input wire logic [4:0] nv_load_data,
  // backed-up time restore, precision option
  input wire logic bk_restore_valid,
  input wire logic [5:0] bk_restore_sec,
  input wire logic [5:0] bk_restore_min,
  input wire logic [4:0] bk_restore_hour,
  // current time
  output logic [5:0] seconds_field,
  output logic [5:0] minutes_field,
  output logic [4:0] hours_field,
  output logic [DAY_W-1:0] elapsed_day_count
);
  initial
  begin
    if (DAY_W < 1 || DAY_W > 32)
      $error("day counter width must be 1 to 32");
  end

  // ****************************************************
  // apb decode
  // ****************************************************
  logic setup;
  logic access;
  logic hit_time, hit_days, hit_zone, hit_server, hit_ctrl;
  logic mapped;
  logic time_ok;
  logic zone_ok;
  logic bad;
  logic wr_time, wr_zone, wr_ctrl;
  logic signed [4:0] zone_in;

  assign setup = psel && !penable;
  assign access = psel && penable;
  assign hit_time = (paddr == todc_pkg::OFS_TIME);
  assign hit_days = (paddr == todc_pkg::OFS_DAYS);
  assign hit_zone = (paddr == todc_pkg::OFS_ZONE);
  assign hit_server = (paddr == todc_pkg::OFS_SERVER);
  assign hit_ctrl = (paddr == todc_pkg::OFS_CTRL);
  assign mapped = hit_time || hit_days || hit_zone || hit_server ||
                  hit_ctrl;
  // fields out of range are refused, time stays as it was
  assign time_ok =
    (pwdata[todc_pkg::SEC_LSB +: todc_pkg::SEC_W] <=
     todc_pkg::SEC_MAX) &&
    (pwdata[todc_pkg::MIN_LSB +: todc_pkg::SEC_W] <=
     todc_pkg::MIN_MAX) &&
    (pwdata[todc_pkg::HOUR_LSB +: todc_pkg::HOUR_W] <=
     todc_pkg::HOUR_MAX);
  assign zone_in = $signed(pwdata[todc_pkg::ZONE_W-1:0]);
  assign zone_ok = (zone_in <= todc_pkg::ZONE_MAX) &&
                   (zone_in >= todc_pkg::ZONE_MIN) &&
                   (pwdata[31:todc_pkg::ZONE_W] ==
                    {(32 - todc_pkg::ZONE_W){pwdata[4]}});
  always_comb
  begin
    bad = !mapped;
    if (pwrite)
    begin
      if (hit_days || hit_server)
        bad = 1'b1;
      else if (hit_time && !time_ok)
        bad = 1'b1;
      else if (hit_zone && !zone_ok)
        bad = 1'b1;
    end
  end

  assign pready = 1'b1;
  assign pslverr = access && bad;
  assign wr_time = access && pwrite && hit_time && !bad;
  assign wr_zone = access && pwrite && hit_zone && !bad;
  assign wr_ctrl = access && pwrite && hit_ctrl && !bad;

  // ****************************************************
  // tick and server conversion
  // ****************************************************
  logic tick;
  logic restart;
  logic conv_busy;
  logic conv_done;
  logic [5:0] conv_sec, conv_min;
  logic [4:0] conv_hour;
  logic bk_load;

  assign bk_load = PRECISION_RTC && bk_restore_valid;
  // a fresh load starts a fresh second
  assign restart = wr_time || conv_done || bk_load;

  todc_tick_div #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .restart(restart),
    .tick(tick)
  );

  // ****************************************************
  // zone offset, server value, settings save
  // ****************************************************
  logic [4:0] current_zone_offset, next_zone;
  logic [31:0] last_server_value, next_server;
  logic next_save_req;
  logic [4:0] next_save_data;

  todc_tz_convert u_conv (
    .pclk(pclk),
    .presetn(presetn),
    .start(srv_valid),
    .value(srv_value),
    .offset(current_zone_offset),
    .busy(conv_busy),
    .done(conv_done),
    .sec(conv_sec),
    .min(conv_min),
    .hour(conv_hour)
  );

  always_comb
  begin
    next_zone = current_zone_offset;
    next_server = last_server_value;
    next_save_req = 1'b0;
    next_save_data = nv_save_data;
    if (wr_zone)
      next_zone = pwdata[todc_pkg::ZONE_W-1:0];
    else if (nv_load_valid)
      next_zone = nv_load_data;
    if (srv_valid)
      next_server = srv_value;
    if (wr_ctrl && pwdata[todc_pkg::CTRL_SAVE_BIT])
    begin
      next_save_req = 1'b1;
      next_save_data = current_zone_offset;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      current_zone_offset <= todc_pkg::ZONE_RESET;
      last_server_value <= 32'h0000_0000;
      nv_save_req <= 1'b0;
      nv_save_data <= todc_pkg::ZONE_RESET;
    end
    else
    begin
      current_zone_offset <= next_zone;
      last_server_value <= next_server;
      nv_save_req <= next_save_req;
      nv_save_data <= next_save_data;
    end
  end

  // ****************************************************
  // time keeping
  // ****************************************************
  logic [5:0] next_sec, next_min;
  logic [4:0] next_hour;
  logic [DAY_W-1:0] next_days;
  logic loaded, next_loaded;
  localparam logic [DAY_W-1:0] DAY_ONE = DAY_W'(1);

  always_comb
  begin
    next_sec = seconds_field;
    next_min = minutes_field;
    next_hour = hours_field;
    next_days = elapsed_day_count;
    next_loaded = loaded;
    if (wr_time)
    begin
      next_sec = pwdata[todc_pkg::SEC_LSB +: todc_pkg::SEC_W];
      next_min = pwdata[todc_pkg::MIN_LSB +: todc_pkg::SEC_W];
      next_hour = pwdata[todc_pkg::HOUR_LSB +: todc_pkg::HOUR_W];
      next_days = '0;
      next_loaded = 1'b1;
    end
    else if (conv_done)
    begin
      next_sec = conv_sec;
      next_min = conv_min;
      next_hour = conv_hour;
      next_days = '0;
      next_loaded = 1'b1;
    end
    else if (bk_load)
    begin
      next_sec = bk_restore_sec;
      next_min = bk_restore_min;
      next_hour = bk_restore_hour;
      next_loaded = 1'b1;
    end
    else if (tick)
    begin
      if (seconds_field >= todc_pkg::SEC_MAX)
      begin
        next_sec = todc_pkg::SEC_RESET;
        if (minutes_field >= todc_pkg::MIN_MAX)
        begin
          next_min = todc_pkg::SEC_RESET;
          if (hours_field >= todc_pkg::HOUR_MAX)
          begin
            next_hour = todc_pkg::HOUR_RESET;
            next_days = elapsed_day_count + DAY_ONE;
          end
          else
            next_hour = hours_field + 5'h01;
        end
        else
          next_min = minutes_field + 6'h01;
      end
      else
        next_sec = seconds_field + 6'h01;
    end
  end

  // time is lost at power loss: reset clears it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      seconds_field <= todc_pkg::SEC_RESET;
      minutes_field <= todc_pkg::SEC_RESET;
      hours_field <= todc_pkg::HOUR_RESET;
      elapsed_day_count <= '0;
      loaded <= 1'b0;
    end
    else
    begin
      seconds_field <= next_sec;
      minutes_field <= next_min;
      hours_field <= next_hour;
      elapsed_day_count <= next_days;
      loaded <= next_loaded;
    end
  end

  // ****************************************************
  // read data
  // ****************************************************
  logic [31:0] next_prdata;
  logic [31:0] rd_word;

  always_comb
  begin
    rd_word = 32'h0000_0000;
    if (hit_time)
    begin
      rd_word[todc_pkg::SEC_LSB +: todc_pkg::SEC_W] = seconds_field;
      rd_word[todc_pkg::MIN_LSB +: todc_pkg::SEC_W] = minutes_field;
      rd_word[todc_pkg::HOUR_LSB +: todc_pkg::HOUR_W] = hours_field;
    end
    else if (hit_days)
      rd_word[DAY_W-1:0] = elapsed_day_count;
    else if (hit_zone)
      rd_word = {{(32 - todc_pkg::ZONE_W){current_zone_offset[4]}},
                 current_zone_offset};
    else if (hit_server)
      rd_word = last_server_value;
    else if (hit_ctrl)
    begin
      rd_word[todc_pkg::STAT_LOADED_BIT] = loaded;
      rd_word[todc_pkg::STAT_BUSY_BIT] = conv_busy;
      rd_word[todc_pkg::STAT_PREC_BIT] = PRECISION_RTC;
    end
    next_prdata = prdata;
    if (setup && !pwrite)
      next_prdata = rd_word;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h0000_0000;
    else
      prdata <= next_prdata;
  end
endmodule // todc_top
`default_nettype wire

// ===== hdl/todc_tz_convert.sv
// server seconds to local hours, minutes, seconds
`timescale 1ns/1ps
`default_nettype none
module todc_tz_convert (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // request
  input wire logic start,
  input wire logic [31:0] value,
  input wire logic [4:0] offset,
  // result
  output logic busy,
  output logic done,
  output logic [5:0] sec,
  output logic [5:0] min,
  output logic [4:0] hour
);
  typedef enum logic [2:0] {CV_IDLE, CV_DIV, CV_HOUR, CV_MIN, CV_ZONE}
    todc_cv_state_e;
  todc_cv_state_e state, next_state;
  logic [31:0] src, next_src;
  logic [16:0] rem, next_rem;
  logic [4:0] cnt, next_cnt, hr, next_hr, off, next_off;
  logic [5:0] mn, next_mn, next_sec, next_min;
  logic [4:0] next_hour;
  logic next_done;
  logic [17:0] rem_sh;
  logic signed [6:0] adj;

  always_comb
  begin
    next_state = state;
    next_src = src;
    next_rem = rem;
    next_cnt = cnt;
    next_hr = hr;
    next_mn = mn;
    next_off = off;
    next_sec = sec;
    next_min = min;
    next_hour = hour;
    next_done = 1'b0;
    rem_sh = {rem, src[31]};
    adj = $signed({2'b00, hr}) + $signed({{2{off[4]}}, off});
    if (adj < 7'sh00)
      adj = adj + todc_pkg::HOURS_PER_DAY;
    else if (adj >= todc_pkg::HOURS_PER_DAY)
      adj = adj - todc_pkg::HOURS_PER_DAY;
    if (start)
    begin
      next_state = CV_DIV;
      next_src = value;
      next_rem = 17'h00000;
      next_cnt = 5'h00;
      next_hr = 5'h00;
      next_mn = 6'h00;
      next_off = offset;
    end
    else
    begin
      unique case (state)
        CV_IDLE: ;
        CV_DIV:
        begin
          // seconds of the day: value modulo one day
          if (rem_sh >= {1'b0, todc_pkg::SECS_PER_DAY})
            next_rem = 17'(rem_sh - {1'b0, todc_pkg::SECS_PER_DAY});
          else
            next_rem = rem_sh[16:0];
          next_src = {src[30:0], 1'b0};
          next_cnt = cnt + 5'h01;
          if (cnt == 5'h1f)
            next_state = CV_HOUR;
        end
        CV_HOUR:
          if (rem >= todc_pkg::SECS_PER_HOUR)
          begin
            next_rem = rem - todc_pkg::SECS_PER_HOUR;
            next_hr = hr + 5'h01;
          end
          else
            next_state = CV_MIN;
        CV_MIN:
          if (rem >= todc_pkg::SECS_PER_MIN)
          begin
            next_rem = rem - todc_pkg::SECS_PER_MIN;
            next_mn = mn + 6'h01;
          end
          else
            next_state = CV_ZONE;
        CV_ZONE:
        begin
          next_sec = rem[5:0];
          next_min = mn;
          next_hour = adj[4:0];
          next_done = 1'b1;
          next_state = CV_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= CV_IDLE;
      src <= 32'h0000_0000;
      rem <= 17'h00000;
      cnt <= 5'h00;
      hr <= 5'h00;
      mn <= 6'h00;
      off <= 5'h00;
      sec <= 6'h00;
      min <= 6'h00;
      hour <= 5'h00;
      done <= 1'b0;
    end
    else
    begin
      state <= next_state;
      src <= next_src;
      rem <= next_rem;
      cnt <= next_cnt;
      hr <= next_hr;
      mn <= next_mn;
      off <= next_off;
      sec <= next_sec;
      min <= next_min;
      hour <= next_hour;
      done <= next_done;
    end
  end

  assign busy = (state != CV_IDLE);
endmodule // todc_tz_convert
`default_nettype wire

// ===== inc/todc_pkg.sv
// constants of the time-of-day clock with zone offset
// Operation
// - seconds field held, range 0 to 59
// - minutes field held, range 0 to 59
// - hours field, 24-hour, range 0 to 23
// - time set loads seconds, minutes, hours
// - time loaded locally or from server
// - day counter restarts on every local or server time load
// - never loaded: days count from power-up
// - processor option loses time at power loss
// - precision option restores time after power cycle
// - signed hour offset limited to plus/minus 12; only processor writes are checked, a load from the store is taken unchecked
// - server time plus offset gives local time
// - last raw server value kept and readable
// - offset saved to non-volatile store on command
package todc_pkg;
  // ****************************************************
  // register map
  // ****************************************************
  localparam logic [7:0] OFS_TIME = 8'h00;
  localparam logic [7:0] OFS_DAYS = 8'h04;
  localparam logic [7:0] OFS_ZONE = 8'h08;
  localparam logic [7:0] OFS_SERVER = 8'h0c;
  localparam logic [7:0] OFS_CTRL = 8'h10;
  localparam int unsigned SEC_LSB = 0;
  localparam int unsigned MIN_LSB = 8;
  localparam int unsigned HOUR_LSB = 16;
  localparam int unsigned SEC_W = 6;
  localparam int unsigned HOUR_W = 5;
  localparam int unsigned ZONE_W = 5;
  localparam int unsigned CTRL_SAVE_BIT = 0;
  localparam int unsigned STAT_LOADED_BIT = 1;
  localparam int unsigned STAT_BUSY_BIT = 2;
  localparam int unsigned STAT_PREC_BIT = 3;
  // ****************************************************
  // field limits and reset values
  // ****************************************************
  localparam logic [5:0] SEC_MAX = 6'h3b;
  localparam logic [5:0] MIN_MAX = 6'h3b;
  localparam logic [4:0] HOUR_MAX = 5'h17;
  localparam logic signed [6:0] HOURS_PER_DAY = 7'sh18;
  localparam logic signed [4:0] ZONE_MAX = 5'sh0c;
  localparam logic signed [4:0] ZONE_MIN = -5'sh0c;
  localparam logic [4:0] ZONE_RESET = 5'h00;
  localparam logic [5:0] SEC_RESET = 6'h00;
  localparam logic [4:0] HOUR_RESET = 5'h00;
  localparam logic [16:0] SECS_PER_DAY = 17'h15180;
  localparam logic [16:0] SECS_PER_HOUR = 17'h00e10;
  localparam logic [16:0] SECS_PER_MIN = 17'h0003c;
  // ****************************************************
  // timing
  // ****************************************************
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned TICK_PERIOD_MS = 1000;
  localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_PERIOD_MS;
endpackage

// ===== testbench/tb_time_of_day_clock_with_tz_offset.sv
// testbench of the time-of-day clock
`timescale 1ns/1ps
`default_nettype none
module tb_time_of_day_clock_with_tz_offset;
  localparam int TC = 8;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic nv_load_valid = 1'b0;
  logic [4:0] nv_load_data = 5'h00;
  logic ask = 1'b0;
  logic [31:0] ask_value = 32'h0;
  logic [3:0] ask_delay = 4'h0;
  logic bk_v = 1'b0;
  logic [16:0] bk_t = 17'h0;
  logic [31:0] prdata, rd, v, srv_value;
  logic pready, pslverr, er, srv_valid, nv_save_req;
  logic [4:0] nv_save_data, hours_field;
  logic [5:0] seconds_field, minutes_field;
  logic [3:0] elapsed_day_count;
  logic [7:0] bad_a [7] = '{8'h14, 8'h14, 8'h04, 8'h0c, 8'h00, 8'h00, 8'h00};
  logic [31:0] bad_d [7] = '{32'h0, 32'h0, 32'h1, 32'h1, 32'h3c,
    32'h3c00, 32'h180000};
  int zt [6] = '{-12, 12, -13, 13, 3, -5};
  int seed, mismatches, checks_done, n, i, z, zl;
  always #2.5 pclk = ~pclk;
  todc_top #(.TICK_CYCLES(TC), .DAY_W(4), .PRECISION_RTC(1'b0)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .srv_valid(srv_valid),
    .srv_value(srv_value), .nv_save_req(nv_save_req),
    .nv_save_data(nv_save_data), .nv_load_valid(nv_load_valid),
    .nv_load_data(nv_load_data), .bk_restore_valid(bk_v),
    .bk_restore_sec(bk_t[5:0]), .bk_restore_min(bk_t[11:6]),
    .bk_restore_hour(bk_t[16:12]),
    .seconds_field(seconds_field), .minutes_field(minutes_field),
    .hours_field(hours_field), .elapsed_day_count(elapsed_day_count));
  todc_srv_model srv (.pclk(pclk), .presetn(presetn), .ask(ask),
    .ask_value(ask_value), .ask_delay(ask_delay), .srv_valid(srv_valid),
    .srv_value(srv_value));
  function automatic int rnd(input int m);
    return int'($unsigned($random(seed)) % m);
  endfunction
  function automatic logic [31:0] exp_time(input logic [31:0] t, input int o);
    int s;
    s = int'(t % 32'd86400);
    return {11'h0, 5'((s / 3600 + o + 24) % 24), 2'h0, 6'(s / 60 % 60), 8'h0};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic limit(input int k, input int m);
    if (k >= m)
    begin
      mismatches++;
      $display("unexpected at %0t: wait ran out", $time);
      end_sim();
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    limit(k, 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic reset_dut();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  initial
  begin
    seed = 32'hde8b6aa2;
    reset_dut();
    for (i = 0; i < 5; i++)
    begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(rd, 32'h0);
    end
    for (i = 0; i < 7; i++)
    begin
      apb(i > 0, bad_a[i], bad_d[i]);
      chk(32'(er), 32'h1);
    end
    $display("test reset and refusals done");
    for (i = 0; i < 8; i++)
    begin
      v = i == 0 ? 32'h00173b3b :
        {11'h0, 5'(rnd(24)), 2'h0, 6'(rnd(60)), 2'h0, 6'(rnd(60))};
      apb(1'b1, 8'h00, v);
      #1;
      chk({11'h0, hours_field, 2'h0, minutes_field, 2'h0, seconds_field}, v);
      chk(32'(elapsed_day_count), 32'h0);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd, v);
    end
    apb(1'b1, 8'h00, 32'h00173b3b);
    n = 0;
    do
    begin
      @(posedge pclk);
      #1;
      n++;
    end
    while (hours_field !== 5'h00 && n < 40);
    chk(32'(n), 32'(TC));
    chk({11'h0, hours_field, 2'h0, minutes_field, 2'h0, seconds_field}, 32'h0);
    chk(32'(elapsed_day_count), 32'h1);
    $display("test time set and rollover done");
    zl = 0;
    foreach (zt[j])
    begin
      apb(1'b1, 8'h08, 32'(zt[j]));
      chk(32'(er), 32'(zt[j] > 12 || zt[j] < -12));
      if (zt[j] <= 12 && zt[j] >= -12)
        zl = zt[j];
      apb(1'b0, 8'h08, 32'h0);
      chk(rd, 32'(zl));
    end
    apb(1'b1, 8'h10, 32'h1);
    #1;
    chk(32'(nv_save_req), 32'h1);
    chk(32'(nv_save_data), 32'h1b);
    @(posedge pclk);
    nv_load_valid <= 1'b1;
    nv_load_data <= 5'h07;
    @(posedge pclk);
    nv_load_valid <= 1'b0;
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h7);
    $display("test zone offset done");
    for (i = 0; i < 6; i++)
    begin
      z = i == 0 ? -12 : i == 1 ? 12 : rnd(25) - 12;
      v = $random(seed);
      v = v - v % 60 + v % 50;
      apb(1'b1, 8'h08, 32'(z));
      @(posedge pclk);
      ask <= 1'b1;
      ask_value <= v;
      ask_delay <= 4'(rnd(16));
      @(posedge pclk);
      ask <= 1'b0;
      #1;
      n = 0;
      while (srv_valid !== 1'b1 && n < 30)
      begin
        @(posedge pclk);
        #1;
        n++;
      end
      limit(n, 30);
      n = 0;
      do
      begin
        apb(1'b0, 8'h10, 32'h0);
        n++;
      end
      while (rd[2] !== 1'b0 && n < 60);
      limit(n, 60);
      chk(rd & 32'h6, 32'h2);
      apb(1'b0, 8'h00, 32'h0);
      chk(rd & 32'h001f3f00, exp_time(v, z));
      chk(32'(elapsed_day_count), 32'h0);
      apb(1'b0, 8'h0c, 32'h0);
      chk(rd, v);
    end
    $display("test server load done");
    reset_dut();
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    // processor option: a backup restore pulse must be ignored
    apb(1'b1, 8'h00, 32'h00010203);
    @(posedge pclk);
    bk_v <= 1'b1;
    bk_t <= 17'(rnd(1 << 17));
    @(posedge pclk);
    bk_v <= 1'b0;
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h00010203);
    $display("test power loss done");
    end_sim();
  end
endmodule // tb_time_of_day_clock_with_tz_offset
`default_nettype wire

// ===== testbench/todc_assertions.sv
// assertions of the time-of-day clock
`timescale 1ns/1ps
`default_nettype none
module todc_assertions #(
  parameter int unsigned DAY_W = 16
) (
  // clock, reset, apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pslverr,
  // server and store
  input wire logic srv_valid,
  input wire logic nv_save_req,
  input wire logic [4:0] nv_save_data,
  // current time
  input wire logic [5:0] seconds_field,
  input wire logic [5:0] minutes_field,
  input wire logic [4:0] hours_field,
  input wire logic [DAY_W-1:0] elapsed_day_count
);
  logic wr;
  logic quiet;
  logic [6:0] hold;
  logic [6:0] next_hold;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  assign wr = psel && penable && pwrite && !pslverr;
  // no server load can be pending
  assign quiet = hold == 7'h00;
  always_comb
  begin
    next_hold = hold == 7'h00 ? 7'h00 : hold - 7'h01;
    if (srv_valid)
      next_hold = 7'h7f;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hold <= 7'h00;
    else
      hold <= next_hold;
  end
  a_sec_range: assert property (seconds_field <= 6'h3b)
    else $error("seconds out of range");
  a_min_range: assert property (minutes_field <= 6'h3b)
    else $error("minutes out of range");
  a_hour_range: assert property (hours_field <= 5'h17)
    else $error("hours out of range");
  a_min_carry: assert property (
    quiet && !$past(wr) && $past(seconds_field) == 6'h3b
      && seconds_field == 6'h00 |-> minutes_field ==
      ($past(minutes_field) == 6'h3b ? 6'h00 : $past(minutes_field) + 6'h01))
    else $error("minute carry wrong");
  a_day_carry: assert property (
    quiet && !$past(wr) && $past(hours_field) == 5'h17
      && hours_field == 5'h00
      |-> elapsed_day_count == $past(elapsed_day_count) + 1'b1)
    else $error("day carry wrong");
  a_time_load: assert property (
    wr && paddr == 8'h00 |=> seconds_field == $past(pwdata[5:0])
      && minutes_field == $past(pwdata[13:8])
      && hours_field == $past(pwdata[20:16]) && elapsed_day_count == '0)
    else $error("time write not loaded");
  a_save_pulse: assert property (
    wr && paddr == 8'h10 && pwdata[0] |=> nv_save_req ##1 !nv_save_req)
    else $error("save pulse wrong");
  a_zone_saved: assert property (
    nv_save_req |-> $signed(nv_save_data) <= 5'sh0c
      && $signed(nv_save_data) >= -5'sh0c)
    else $error("saved offset out of range");
endmodule // todc_assertions
bind todc_top todc_assertions #(.DAY_W(DAY_W)) u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
  .srv_valid(srv_valid), .nv_save_req(nv_save_req),
  .nv_save_data(nv_save_data), .seconds_field(seconds_field),
  .minutes_field(minutes_field), .hours_field(hours_field),
  .elapsed_day_count(elapsed_day_count)
);
`default_nettype wire

// ===== testbench/todc_srv_model.sv
// network time server model
`timescale 1ns/1ps
`default_nettype none
module todc_srv_model (
  // bench request
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ask,
  input wire logic [31:0] ask_value,
  input wire logic [3:0] ask_delay,
  // reply
  output logic srv_valid,
  output logic [31:0] srv_value
);
  logic [4:0] cnt;
  logic [31:0] held;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= 5'h00;
      held <= 32'h0;
      srv_valid <= 1'b0;
      srv_value <= 32'h0;
    end
    else
    begin
      srv_valid <= cnt == 5'h01;
      // value only valid with the pulse
      srv_value <= cnt == 5'h01 ? held : ~srv_value;
      if (ask)
      begin
        held <= ask_value;
        cnt <= {1'b0, ask_delay} + 5'h02;
      end
      else if (cnt != 5'h00)
        cnt <= cnt - 5'h01;
    end
  end
endmodule // todc_srv_model
`default_nettype wire
